/* logic/alt_pkg.sv */
// constants and types shared by the alert limit threshold bank
// assumes a single core clock; offsets are the register pointer values seen over the two-wire bus
package alt_pkg;
    localparam int unsigned NUM_THR = 6;

    // register pointer values
    localparam logic [7:0] OFS_CUR_HI  = 8'h0C;
    localparam logic [7:0] OFS_CUR_LO  = 8'h0D;
    localparam logic [7:0] OFS_BUS_HI  = 8'h0E;
    localparam logic [7:0] OFS_BUS_LO  = 8'h0F;
    localparam logic [7:0] OFS_TEMP_HI = 8'h10;
    localparam logic [7:0] OFS_PWR_HI  = 8'h11;
    localparam logic [7:0] OFS_ID      = 8'h3E;

    // reset values
    localparam logic [15:0] RST_CUR_HI  = 16'h7FFF;
    localparam logic [15:0] RST_CUR_LO  = 16'h8000;
    localparam logic [15:0] RST_BUS_HI  = 16'h7FFF;
    localparam logic [15:0] RST_BUS_LO  = 16'h0000;
    localparam logic [15:0] RST_TEMP_HI = 16'h07FF;
    localparam logic [15:0] RST_PWR_HI  = 16'h0FFF;

    // writable bits; bit 15 of both bus limits is reserved
    localparam logic [15:0] MASK_FULL = 16'hFFFF;
    localparam logic [15:0] MASK_BUS  = 16'h7FFF;

    localparam logic [15:0] THR_RST [NUM_THR] = '{RST_CUR_HI, RST_CUR_LO, RST_BUS_HI,
                                                  RST_BUS_LO, RST_TEMP_HI, RST_PWR_HI};
    localparam logic [15:0] THR_MASK [NUM_THR] = '{MASK_FULL, MASK_FULL, MASK_BUS,
                                                   MASK_BUS, MASK_FULL, MASK_FULL};

    // bus address and maker code: values are arbitrary
    localparam logic [6:0]  DEF_DEV_ADDR   = 7'h40;
    localparam logic [15:0] DEF_MAKER_CODE = 16'h4142;

    // result widths and threshold alignment pads
    localparam int unsigned CUR_W  = 20;
    localparam int unsigned BUS_W  = 20;
    localparam int unsigned TEMP_W = 16;
    localparam int unsigned PWR_W  = 24;
    localparam logic [3:0]  RES_PAD = 4'h0;
    localparam logic [7:0]  PWR_PAD = 8'h00;

    // bit positions within one nine-clock byte slot
    localparam logic [3:0] BIT_ACK = 4'h7;
    localparam logic [3:0] BIT_END = 4'h8;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_PTR,
        PH_WR_HI,
        PH_WR_LO,
        PH_RD_HI,
        PH_RD_LO,
        PH_IGNORE
    } alt_phase_type;
endpackage

/* logic/alt_thr_if.sv */
// threshold values passed from the register bank to the comparators
// assumes both ends sit on the same core clock
`timescale 1ns/10ps
interface alt_thr_if;
    logic [15:0] current_high_threshold;
    logic [15:0] current_low_threshold;
    logic [15:0] bus_high_threshold;
    logic [15:0] bus_low_threshold;
    logic [15:0] temperature_high_threshold;
    logic [15:0] power_high_threshold;

    modport bank (
        output current_high_threshold,
        output current_low_threshold,
        output bus_high_threshold,
        output bus_low_threshold,
        output temperature_high_threshold,
        output power_high_threshold
    );
    modport cmp (
        input current_high_threshold,
        input current_low_threshold,
        input bus_high_threshold,
        input bus_low_threshold,
        input temperature_high_threshold,
        input power_high_threshold
    );
endinterface

/* logic/alt_limit_cmp.sv */
// limit comparators: measurement results against the programmed thresholds
// assumes results come from logic on the same clock with a one-cycle valid strobe
`timescale 1ns/10ps
module alt_limit_cmp (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    alt_thr_if.cmp                            thr,
    input  wire logic [alt_pkg::CUR_W-1:0]    cur_result,
    input  wire logic [alt_pkg::BUS_W-1:0]    bus_result,
    input  wire logic [alt_pkg::TEMP_W-1:0]   temp_result,
    input  wire logic [alt_pkg::PWR_W-1:0]    power_result,
    input  wire logic                         result_valid,
    output logic                              overcurrent_flag,
    output logic                              undercurrent_flag,
    output logic                              bus_over_flag,
    output logic                              bus_under_flag,
    output logic                              overtemperature_flag,
    output logic                              power_over_flag
);
    // thresholds widened to result scale: one current or bus threshold lsb is sixteen result lsbs, one power threshold lsb is 256
    logic [alt_pkg::CUR_W-1:0] cur_hi_ext;
    logic [alt_pkg::CUR_W-1:0] cur_lo_ext;
    logic [alt_pkg::BUS_W-1:0] bus_hi_ext;
    logic [alt_pkg::BUS_W-1:0] bus_lo_ext;
    logic [alt_pkg::PWR_W-1:0] pwr_hi_ext;

    assign cur_hi_ext = {thr.current_high_threshold, alt_pkg::RES_PAD};
    assign cur_lo_ext = {thr.current_low_threshold, alt_pkg::RES_PAD};
    assign bus_hi_ext = {1'b0, thr.bus_high_threshold[14:0], alt_pkg::RES_PAD};
    assign bus_lo_ext = {1'b0, thr.bus_low_threshold[14:0], alt_pkg::RES_PAD};
    assign pwr_hi_ext = {thr.power_high_threshold, alt_pkg::PWR_PAD};

    ////////////////////////////////////////////////////////////////////////////////
    // flags refresh only on a new result, otherwise they hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overcurrent_flag     <= 1'b0;
            undercurrent_flag    <= 1'b0;
            bus_over_flag        <= 1'b0;
            bus_under_flag       <= 1'b0;
            overtemperature_flag <= 1'b0;
            power_over_flag      <= 1'b0;
        end else if (result_valid) begin
            // signed compare, so a negative limit trips on zero current
            overcurrent_flag     <= $signed(cur_result) > $signed(cur_hi_ext);
            undercurrent_flag    <= $signed(cur_result) < $signed(cur_lo_ext);
            bus_over_flag        <= $signed(bus_result) > $signed(bus_hi_ext);
            bus_under_flag       <= $signed(bus_result) < $signed(bus_lo_ext);
            overtemperature_flag <= $signed(temp_result)
                                    > $signed(thr.temperature_high_threshold);
            // no sign applied to power
            power_over_flag      <= power_result > pwr_hi_ext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    zero_trip_a: assert property (result_valid && cur_result == 20'h00000
        && thr.current_high_threshold[15] |=> overcurrent_flag)
        else $error("negative over limit did not trip at zero current");
    cur_cmp_a: assert property (result_valid |=>
        overcurrent_flag == ($signed($past(cur_result))
            > $signed({$past(thr.current_high_threshold), 4'h0}))
        && undercurrent_flag == ($signed($past(cur_result))
            < $signed({$past(thr.current_low_threshold), 4'h0})))
        else $error("current flags disagree with thresholds");
    // both limits may be programmed crossed, so the under limit is kept out of the way
    bus_cmp_a: assert property (result_valid && !bus_result[19]
        && bus_result > {1'b0, thr.bus_high_threshold[14:0], 4'h0}
        && bus_result >= {1'b0, thr.bus_low_threshold[14:0], 4'h0}
        |=> bus_over_flag && !bus_under_flag)
        else $error("bus over limit missed");
    temp_cmp_a: assert property (result_valid |=> overtemperature_flag ==
        ($signed($past(temp_result)) > $signed($past(thr.temperature_high_threshold))))
        else $error("temperature flag wrong");
    pwr_scale_a: assert property (result_valid
        && power_result == {thr.power_high_threshold, 8'h00} |=> !power_over_flag)
        else $error("power limit scaling wrong");
    cur_align_a: assert property (result_valid
        && cur_result == {thr.current_high_threshold, 4'hF}
        && thr.current_high_threshold != 16'h7FFF |=> overcurrent_flag)
        else $error("current threshold not aligned to result");
    flag_hold_a: assert property (!result_valid |=> $stable({overcurrent_flag,
        undercurrent_flag, bus_over_flag, bus_under_flag, overtemperature_flag, power_over_flag}))
        else $error("flags moved without a result");
endmodule // alt_limit_cmp

/* logic/alt_limit_regs.sv */
// alert limit threshold register bank with two-wire bus slave and limit comparators
// assumes scl/sda arrive asynchronously; results come from same-clock logic
//
// Summary of operation
// - a negative current over limit trips overcurrent even at zero current.
// - current over limit is 16-bit signed read/write, 1.2 mA/lsb, reset 7FFFh.
// - current under limit is 16-bit signed read/write, 1.2 mA/lsb, reset 8000h.
// - bit 15 of both bus voltage limits is reserved and always reads zero.
// - bus over limit is 15-bit unsigned in bits 14-0, 3.125 mV/lsb, reset 7FFFh.
// - bus under limit is 15-bit unsigned in bits 14-0, 3.125 mV/lsb, reset zero.
// - temperature limit is 16-bit signed read/write, compared direct, reset 7FFh.
// - power limit is 256 power result lsbs per lsb, widened by eight zero bits, reset FFFh.
// - power limit is 16-bit unsigned read/write with no sign in its compare.
// - a read-only 16-bit maker code of two ascii characters ignores writes.
// - overcurrent sets above the over limit, undercurrent below the under limit.
// - bus over flag sets above the bus over limit, bus under flag below the under limit.
// - power flag sets above the power limit, temperature flag above its limit.
`timescale 1ns/10ps
module alt_limit_regs #(
    parameter logic [6:0]  DEV_ADDR   = alt_pkg::DEF_DEV_ADDR,
    parameter logic [15:0] MAKER_CODE = alt_pkg::DEF_MAKER_CODE
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    input  wire logic [alt_pkg::CUR_W-1:0]    cur_result,
    input  wire logic [alt_pkg::BUS_W-1:0]    bus_result,
    input  wire logic [alt_pkg::TEMP_W-1:0]   die_temperature_result,
    input  wire logic [alt_pkg::PWR_W-1:0]    power_result,
    input  wire logic                         result_valid,
    output logic                              overcurrent_flag,
    output logic                              undercurrent_flag,
    output logic                              bus_over_flag,
    output logic                              bus_under_flag,
    output logic                              overtemperature_flag,
    output logic                              power_over_flag
);
    logic [2:0]            scl_sync_q;
    logic [2:0]            sda_sync_q;
    logic                  scl_f_q;
    logic                  sda_f_q;
    logic                  scl_p_q;
    logic                  sda_p_q;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  bus_start;
    logic                  bus_stop;
    alt_pkg::alt_phase_type phase_q;
    logic [3:0]            cnt_q;
    logic [7:0]            sh_q;
    logic [7:0]            ptr_q;
    logic [7:0]            hi_q;
    logic [15:0]           rd_q;
    logic                  drv_q;
    logic                  mack_q;
    logic                  addr_hit;
    logic                  rd_phase;
    logic [7:0]            tx_byte;
    logic [2:0]            bit_sel;
    logic                  wr_en;
    logic [15:0]           wr_data;
    logic [15:0]           rd_mux;
    logic [2:0]            thr_idx;
    logic [15:0]           thr_q [alt_pkg::NUM_THR];

    alt_thr_if thr ();

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; a level counts once the second and third stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_in};
            sda_sync_q <= {sda_sync_q[1:0], sda_in};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            if (scl_sync_q[1] == scl_sync_q[2]) begin
                scl_f_q <= scl_sync_q[2];
            end
            if (sda_sync_q[1] == sda_sync_q[2]) begin
                sda_f_q <= sda_sync_q[2];
            end
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    assign scl_rise  = scl_f_q & ~scl_p_q;
    assign scl_fall  = ~scl_f_q & scl_p_q;
    assign bus_start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
    assign bus_stop  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

    ////////////////////////////////////////////////////////////////////////////////
    // byte-slot protocol: address, pointer, then msb-first data words
    assign addr_hit = (sh_q[7:1] == DEV_ADDR);
    assign rd_phase = (phase_q == alt_pkg::PH_RD_HI) || (phase_q == alt_pkg::PH_RD_LO);
    assign tx_byte  = (phase_q == alt_pkg::PH_RD_HI) ? rd_q[15:8] : rd_q[7:0];
    assign bit_sel  = 3'(4'h6 - cnt_q);
    assign wr_en    = scl_fall && cnt_q == alt_pkg::BIT_ACK && phase_q == alt_pkg::PH_WR_LO;
    assign wr_data  = {hi_q, sh_q};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= alt_pkg::PH_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 8'h00;
            hi_q    <= 8'h00;
            rd_q    <= 16'h0000;
            drv_q   <= 1'b0;
            mack_q  <= 1'b0;
        end else if (bus_start) begin
            phase_q <= alt_pkg::PH_ADDR;
            // the scl fall closing the start wraps this to zero, so it is not counted as a bit
            cnt_q   <= 4'hF;
            drv_q   <= 1'b0;
        end else if (bus_stop) begin
            phase_q <= alt_pkg::PH_IDLE;
            drv_q   <= 1'b0;
        end else if (phase_q != alt_pkg::PH_IDLE) begin
            if (scl_rise) begin
                if (cnt_q != alt_pkg::BIT_END) begin
                    sh_q <= {sh_q[6:0], sda_f_q};
                end else begin
                    mack_q <= ~sda_f_q;
                end
            end
            if (scl_fall) begin
                if (cnt_q == alt_pkg::BIT_ACK) begin
                    cnt_q <= alt_pkg::BIT_END;
                    case (phase_q)
                        alt_pkg::PH_ADDR: drv_q <= addr_hit;
                        alt_pkg::PH_PTR: begin
                            ptr_q <= sh_q;
                            drv_q <= 1'b1;
                        end
                        alt_pkg::PH_WR_HI: begin
                            hi_q  <= sh_q;
                            drv_q <= 1'b1;
                        end
                        alt_pkg::PH_WR_LO: drv_q <= 1'b1;
                        default: drv_q <= 1'b0;
                    endcase
                end else if (cnt_q == alt_pkg::BIT_END) begin
                    cnt_q <= 4'h0;
                    drv_q <= 1'b0;
                    case (phase_q)
                        alt_pkg::PH_ADDR: begin
                            if (!addr_hit) begin
                                phase_q <= alt_pkg::PH_IGNORE;
                            end else if (sh_q[0]) begin
                                phase_q <= alt_pkg::PH_RD_HI;
                                rd_q    <= rd_mux;
                                drv_q   <= ~rd_mux[15];
                            end else begin
                                phase_q <= alt_pkg::PH_PTR;
                            end
                        end
                        alt_pkg::PH_PTR:   phase_q <= alt_pkg::PH_WR_HI;
                        alt_pkg::PH_WR_HI: phase_q <= alt_pkg::PH_WR_LO;
                        alt_pkg::PH_WR_LO: phase_q <= alt_pkg::PH_WR_HI;
                        alt_pkg::PH_RD_HI: begin
                            if (mack_q) begin
                                phase_q <= alt_pkg::PH_RD_LO;
                                drv_q   <= ~rd_q[7];
                            end else begin
                                phase_q <= alt_pkg::PH_IGNORE;
                            end
                        end
                        alt_pkg::PH_RD_LO: begin
                            // host acked: send the same register again
                            if (mack_q) begin
                                phase_q <= alt_pkg::PH_RD_HI;
                                rd_q    <= rd_mux;
                                drv_q   <= ~rd_mux[15];
                            end else begin
                                phase_q <= alt_pkg::PH_IGNORE;
                            end
                        end
                        default: phase_q <= alt_pkg::PH_IGNORE;
                    endcase
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                    drv_q <= rd_phase & ~tx_byte[bit_sel];
                end
            end
        end
    end

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = drv_q;

    ////////////////////////////////////////////////////////////////////////////////
    // threshold registers; the maker code has no storage, so writes to it vanish
    generate
        for (genvar i = 0; i < alt_pkg::NUM_THR; i++) begin : g_thr
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    thr_q[i] <= alt_pkg::THR_RST[i];
                end else if (wr_en && ptr_q == alt_pkg::OFS_CUR_HI + 8'(i)) begin
                    thr_q[i] <= wr_data & alt_pkg::THR_MASK[i];
                end
            end
        end
    endgenerate

    assign thr.current_high_threshold     = thr_q[0];
    assign thr.current_low_threshold      = thr_q[1];
    assign thr.bus_high_threshold         = thr_q[2];
    assign thr.bus_low_threshold          = thr_q[3];
    assign thr.temperature_high_threshold = thr_q[4];
    assign thr.power_high_threshold       = thr_q[5];

    assign thr_idx = 3'(ptr_q - alt_pkg::OFS_CUR_HI);

    // unmapped pointers read zero
    always_comb begin
        rd_mux = 16'h0000;
        if (ptr_q >= alt_pkg::OFS_CUR_HI && ptr_q <= alt_pkg::OFS_PWR_HI) begin
            rd_mux = thr_q[thr_idx];
        end else if (ptr_q == alt_pkg::OFS_ID) begin
            rd_mux = MAKER_CODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // comparator flags; ordering of the two current limits is left to software
    alt_limit_cmp u_cmp (
        .clk                  (clk),
        .rst_n                (rst_n),
        .thr                  (thr.cmp),
        .cur_result           (cur_result),
        .bus_result           (bus_result),
        .temp_result          (die_temperature_result),
        .power_result         (power_result),
        .result_valid         (result_valid),
        .overcurrent_flag     (overcurrent_flag),
        .undercurrent_flag    (undercurrent_flag),
        .bus_over_flag        (bus_over_flag),
        .bus_under_flag       (bus_under_flag),
        .overtemperature_flag (overtemperature_flag),
        .power_over_flag      (power_over_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence reg_write_s(logic [7:0] ofs);
        wr_en && ptr_q == ofs;
    endsequence

    cur_hi_write_a: assert property (reg_write_s(alt_pkg::OFS_CUR_HI)
        |=> thr_q[0] == $past(wr_data))
        else $error("current over limit write lost");
    cur_lo_write_a: assert property (reg_write_s(alt_pkg::OFS_CUR_LO)
        |=> thr_q[1] == $past(wr_data))
        else $error("current under limit write lost");
    bus_rsv_a: assert property (thr_q[2][15] == 1'b0 && thr_q[3][15] == 1'b0)
        else $error("reserved bus limit bit set");
    bus_hi_write_a: assert property (reg_write_s(alt_pkg::OFS_BUS_HI)
        |=> thr_q[2][14:0] == $past(wr_data[14:0]))
        else $error("bus over limit write lost");
    bus_lo_write_a: assert property (reg_write_s(alt_pkg::OFS_BUS_LO)
        |=> thr_q[3][14:0] == $past(wr_data[14:0]))
        else $error("bus under limit write lost");
    temp_write_a: assert property (reg_write_s(alt_pkg::OFS_TEMP_HI)
        |=> thr_q[4] == $past(wr_data))
        else $error("temperature limit write lost");
    pwr_write_a: assert property (reg_write_s(alt_pkg::OFS_PWR_HI)
        |=> thr_q[5] == $past(wr_data))
        else $error("power limit write lost");
    maker_read_a: assert property (rd_phase && ptr_q == alt_pkg::OFS_ID
        |-> rd_q == MAKER_CODE)
        else $error("maker code read wrong");
endmodule // alt_limit_regs

/* tb/alt_host_model.sv */
// two-wire host model: drives scl and an open-drain pull on sda
// assumes the bench resolves sda with a pull-up
`timescale 1ns/10ps
module alt_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    localparam int HALF = 12;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // sda moves two clocks after scl falls, so the pin filter never sees a false start
    task automatic slot(input logic b, output logic r);
        sda_low <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF - 1);
        r = sda;
        tick(1);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic start();
        sda_low <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b0;
        tick(HALF);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) slot(tx[i], rx[i]);
        slot(ab, ack);
    endtask
endmodule // alt_host_model

/* tb/test_alt_limit_regs.sv */
// self-checking bench for the alert limit threshold bank
// assumes a 20 MHz clock and the host model on the two-wire pins
`timescale 1ns/10ps
module test_alt_limit_regs;
    logic        clk;
    logic        rst_n;
    logic        scl;
    logic        sda_low;
    logic        sda_out;
    logic        sda_oe;
    wire logic   sda;
    logic [19:0] cur;
    logic [19:0] bus;
    logic [15:0] temp;
    logic [23:0] pwr;
    logic        valid;
    logic [5:0]  flags;
    int          err_count;
    int          num_checks;
    int          cycles = 0;
    localparam logic [7:0] ADW = {alt_pkg::DEF_DEV_ADDR, 1'b0};
    assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    alt_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    alt_limit_regs dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .cur_result(cur), .bus_result(bus),
        .die_temperature_result(temp), .power_result(pwr), .result_valid(valid),
        .overcurrent_flag(flags[5]), .undercurrent_flag(flags[4]), .bus_over_flag(flags[3]),
        .bus_under_flag(flags[2]), .overtemperature_flag(flags[1]),
        .power_over_flag(flags[0]));
    task automatic end_sim();
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flags(input logic [5:0] got, input logic [5:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t flags %b expected %b", $time, got, exp);
        end
    endtask
    // acks are packed into a word that must be all zero
    task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
        logic [7:0] rx;
        logic [3:0] a;
        host.start();
        host.xfer(ADW, 1'b1, rx, a[3]);
        host.xfer(ptr, 1'b1, rx, a[2]);
        host.xfer(d[15:8], 1'b1, rx, a[1]);
        host.xfer(d[7:0], 1'b1, rx, a[0]);
        host.stop();
        chk_word({12'h000, a}, 16'h0000);
    endtask
    task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [3:0] a;
        host.start();
        host.xfer(ADW, 1'b1, hi, a[3]);
        host.xfer(ptr, 1'b1, hi, a[2]);
        host.start();
        host.xfer(ADW | 8'h01, 1'b1, hi, a[1]);
        host.xfer(8'hFF, 1'b0, hi, a[0]);
        host.xfer(8'hFF, 1'b1, lo, a[0]);
        host.stop();
        chk_word({13'h0000, a[3:1]}, 16'h0000);
        chk_word({hi, lo}, exp);
    endtask
    task automatic meas(input logic [19:0] c, input logic [19:0] b, input logic [15:0] t,
                        input logic [23:0] p, input logic [5:0] exp);
        @(posedge clk);
        cur <= c;
        bus <= b;
        temp <= t;
        pwr <= p;
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        @(posedge clk);
        #1;
        chk_flags(flags, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        rst_n = 1'b0;
        {cur, bus, temp, pwr, valid} = '0;
        err_count = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        host.tick(6);
        rd(alt_pkg::OFS_CUR_HI, 16'h7FFF);
        rd(alt_pkg::OFS_CUR_LO, 16'h8000);
        rd(alt_pkg::OFS_BUS_HI, 16'h7FFF);
        rd(alt_pkg::OFS_BUS_LO, 16'h0000);
        rd(alt_pkg::OFS_TEMP_HI, 16'h07FF);
        rd(alt_pkg::OFS_PWR_HI, 16'h0FFF);
        wr(alt_pkg::OFS_ID, 16'h0000);
        rd(alt_pkg::OFS_ID, alt_pkg::DEF_MAKER_CODE);
        wr(alt_pkg::OFS_BUS_HI, 16'hFFFF);
        rd(alt_pkg::OFS_BUS_HI, 16'h7FFF);
        wr(alt_pkg::OFS_BUS_HI, 16'h0010);
        wr(alt_pkg::OFS_BUS_LO, 16'h8010);
        rd(alt_pkg::OFS_BUS_LO, 16'h0010);
        wr(alt_pkg::OFS_CUR_HI, 16'h0010);
        wr(alt_pkg::OFS_CUR_LO, 16'h0010);
        wr(alt_pkg::OFS_TEMP_HI, 16'h0100);
        wr(alt_pkg::OFS_PWR_HI, 16'h8000);
        rd(alt_pkg::OFS_PWR_HI, 16'h8000);
        // current sits at the top of the limit's sixteen-result-lsb step
        meas(20'h0010F, 20'h00101, 16'h0101, 24'h800001, 6'b101011);
        meas(20'h000FF, 20'h000FF, 16'h0100, 24'h800000, 6'b010100);
        meas(20'h00100, 20'h00100, 16'hFF00, 24'h000000, 6'b000000);
        wr(alt_pkg::OFS_CUR_LO, 16'hFFF0);
        wr(alt_pkg::OFS_CUR_HI, 16'hFFFF);
        meas(20'h00000, 20'h00100, 16'h0000, 24'h000000, 6'b100000);
        end_sim();
    end
endmodule // test_alt_limit_regs
